// *** core/hw_impl_control_regs.svh ***
// Register offsets, field positions and reset values of the control register bank.
`ifndef HW_IMPL_CONTROL_REGS_SVH
`define HW_IMPL_CONTROL_REGS_SVH

`define OFS_HW_CONFIG_0    8'h00
`define OFS_PLL_READBACK   8'h04
`define OFS_PERF_CNT_3     8'h08
`define OFS_PERF_CNT_4     8'h0c
`define OFS_EVENT_SEL_1    8'h10
`define OFS_IRQ_STATUS     8'h14
`define OFS_IRQ_MASK       8'h18

`define CFG_MC_PIN_EN      0
`define CFG_CACHE_PAR_EN   1
`define CFG_ADDR_PAR_EN    2
`define CFG_DATA_PAR_EN    3
`define CFG_SNOOP_NORESTORE 7
`define CFG_NOT_HARD_RESET 15
`define CFG_ICACHE_EN      16
`define CFG_DCACHE_EN      17
`define CFG_ICACHE_LOCK    18
`define CFG_DCACHE_LOCK    19
`define CFG_ICACHE_INVAL   20
`define CFG_DCACHE_INVAL   21

`define CFG_WRITE_MASK     32'h003f808f
`define CFG_RESET          32'h00000000

`define EVSEL_C3_LSB       0
`define EVSEL_C4_LSB       8
`define EVSEL_RESET        32'h00000000

`define IRQ_MCHECK         0
`define IRQ_CNT3_NEG       1
`define IRQ_CNT4_NEG       2
`define IRQ_WIDTH          3

`define AXI_RESP_OKAY      2'b00
`define AXI_RESP_SLVERR    2'b10

`endif

// *** core/hw_impl_control_pkg.sv ***
// Types shared by the control register bank.
`include "hw_impl_control_regs.svh"
package hw_impl_control_pkg;

   typedef logic [31:0] word_type;
   typedef logic [7:0]  addr_type;
   typedef logic [1:0]  resp_type;

   typedef enum logic [1:0] {
      wr_idle,
      wr_resp
   } wr_state_type;

endpackage : hw_impl_control_pkg

// *** core/hw_impl_control_regs.sv ***
// Implementation-dependent control, clock readback and counter registers over AXI4-Lite.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "hw_impl_control_regs.svh"

// Notes on behaviour
// (RQ1) Configuration bit 0 clear blocks every machine-check source, the input included.
// (RQ2) Every enabled machine check is further qualified by the machine-check gate.
// (RQ3) Configuration bit 1 gates machine check on cache parity errors.
// (RQ4) Configuration bit 2 gates machine check on address bus parity errors.
// (RQ5) Configuration bit 3 gates machine check on data bus parity errors.
// (RQ6) Bit 7 set stops driving shared and retry responses back high.
// (RQ7) With restore disabled, system logic itself returns those responses high.
// (RQ8) Bit 15 is set by software, cleared by hard reset.
// (RQ9) Bit 16 clear: instruction cache unused, fetches inhibited, snoops ignored.
// (RQ10) Bit 17 clear: data cache unused, accesses inhibited, snoops ignored.
// (RQ11) Lock bits 18 and 19 make misses cache-inhibited without allocation.
// (RQ12) Block-zero while the data cache is locked raises an alignment exception.
// (RQ13) Clock readback is read-only: pins in bits 0-3, zeros above.
// (RQ14) Counters 3 and 4 are 32 bits and may interrupt while negative.
// (RQ15) Event select register 1 chooses what counters 3 and 4 count.
// (RQ16) Bits 20 and 21 invalidate an enabled cache, block it, self-clear.
// (RQ17) Unused configuration bits ignore writes and read as zero.
module hw_impl_control_regs #(
   parameter int EVENTS = 8
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire hw_impl_control_pkg::addr_type s_axi_awaddr,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   input  wire hw_impl_control_pkg::word_type s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   output hw_impl_control_pkg::resp_type      s_axi_bresp,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   input  wire hw_impl_control_pkg::addr_type s_axi_araddr,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   output hw_impl_control_pkg::word_type      s_axi_rdata,
   output hw_impl_control_pkg::resp_type      s_axi_rresp,
   input  wire logic                          machine_check_input,
   input  wire logic                          cache_parity_err,
   input  wire logic                          addr_parity_err,
   input  wire logic                          data_parity_err,
   input  wire logic                          machine_check_gate,
   input  wire logic [3:0]                    pll_cfg_pins,
   input  wire logic [EVENTS-1:0]             perf_events,
   input  wire logic                          dcbz_exec,
   input  wire logic                          icache_inval_busy,
   input  wire logic                          dcache_inval_busy,
   output logic                               machine_check_take,
   output logic                               checkstop,
   output logic                               snoop_restore_en,
   output logic                               icache_active,
   output logic                               dcache_active,
   output logic                               icache_no_alloc,
   output logic                               dcache_no_alloc,
   output logic                               icache_inval_start,
   output logic                               dcache_inval_start,
   output logic                               dcbz_align_exc,
   output logic                               irq
);
   import hw_impl_control_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      wr_state_type wst;
      logic         bvalid;
      logic         aw_got;
      logic         w_got;
      addr_type     awaddr;
      word_type     wdata;
      logic [3:0]   wstrb;
      resp_type     bresp;
      logic         awready;
      logic         wready;
      logic         arready;
      logic         rvalid;
      word_type     rdata;
      resp_type     rresp;
      word_type     cfg;
      word_type     cnt3;
      word_type     cnt4;
      word_type     evsel;
      logic [`IRQ_WIDTH-1:0] status;
      logic [`IRQ_WIDTH-1:0] mask;
      logic         mc_take;
      logic         chkstop;
      logic         snoop_rest;
      logic         ic_act;
      logic         dc_act;
      logic         ic_na;
      logic         dc_na;
      logic         ic_inv;
      logic         dc_inv;
      logic         align_exc;
      logic         irq;
   } state_type;

   state_type s_q;
   state_type s_d;

   function automatic word_type merge_bytes(word_type old, word_type nw, logic [3:0] strb);
      word_type r;
      for (int i = 0; i < 4; i++)
      begin
         r[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
      return r;
   endfunction : merge_bytes

   function automatic logic is_mapped(addr_type a);
      return (a == `OFS_HW_CONFIG_0) || (a == `OFS_PLL_READBACK) || (a == `OFS_PERF_CNT_3)
          || (a == `OFS_PERF_CNT_4) || (a == `OFS_EVENT_SEL_1) || (a == `OFS_IRQ_STATUS)
          || (a == `OFS_IRQ_MASK);
   endfunction : is_mapped

   function automatic logic event_pick(logic [EVENTS-1:0] ev, logic [7:0] sel);
      return (32'(sel) < EVENTS) ? ev[sel[$clog2(EVENTS)-1:0]] : 1'b0;
   endfunction : event_pick

   // (RQ3) (RQ4) (RQ5) parity source gating
   logic mc_cause;
   assign mc_cause = (machine_check_input
                      || (s_q.cfg[`CFG_CACHE_PAR_EN] && cache_parity_err)
                      || (s_q.cfg[`CFG_ADDR_PAR_EN] && addr_parity_err)
                      || (s_q.cfg[`CFG_DATA_PAR_EN] && data_parity_err))
                     && s_q.cfg[`CFG_MC_PIN_EN];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [`IRQ_WIDTH-1:0] ev;
      logic                  wr_fire;
      word_type              wv;
      ev      = '0;
      wr_fire = 1'b0;
      wv      = '0;
      s_d     = s_q;

      // Write channel: address and data taken in either order.
      if (s_q.awready && s_axi_awvalid)
      begin
         s_d.aw_got  = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
         s_d.awready = 1'b0;
      end
      if (s_q.wready && s_axi_wvalid)
      begin
         s_d.w_got  = 1'b1;
         s_d.wdata  = s_axi_wdata;
         s_d.wstrb  = s_axi_wstrb;
         s_d.wready = 1'b0;
      end

      // Self-clearing invalidate bits drop the cycle after they are written.
      // (RQ16) invalidate bits self-clear
      s_d.cfg[`CFG_ICACHE_INVAL] = 1'b0;
      s_d.cfg[`CFG_DCACHE_INVAL] = 1'b0;

      // Counters run on the selected event; a bus write below takes precedence.
      // (RQ15) event selection steers counting
      if (event_pick(perf_events, s_q.evsel[`EVSEL_C3_LSB +: 8]))
      begin
         s_d.cnt3 = s_q.cnt3 + 32'h1;
      end
      if (event_pick(perf_events, s_q.evsel[`EVSEL_C4_LSB +: 8]))
      begin
         s_d.cnt4 = s_q.cnt4 + 32'h1;
      end

      case (s_q.wst)
         wr_idle:
         begin
            if (s_q.aw_got && s_q.w_got)
            begin
               wr_fire  = 1'b1;
               s_d.wst  = wr_resp;
               s_d.bvalid = 1'b1;
               s_d.bresp = is_mapped(s_q.awaddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end
         end
         wr_resp:
         begin
            if (s_axi_bready)
            begin
               s_d.wst     = wr_idle;
               s_d.bvalid  = 1'b0;
               s_d.aw_got  = 1'b0;
               s_d.w_got   = 1'b0;
               s_d.awready = 1'b1;
               s_d.wready  = 1'b1;
            end
         end
         default: s_d.wst = wr_idle;
      endcase

      if (wr_fire)
      begin
         case (s_q.awaddr)
            `OFS_HW_CONFIG_0:
            begin
               // (RQ17) unused bits dropped
               wv    = merge_bytes(s_q.cfg, s_q.wdata, s_q.wstrb);
               s_d.cfg = wv & `CFG_WRITE_MASK;
            end
            `OFS_PERF_CNT_3:  s_d.cnt3   = merge_bytes(s_q.cnt3, s_q.wdata, s_q.wstrb);
            `OFS_PERF_CNT_4:  s_d.cnt4   = merge_bytes(s_q.cnt4, s_q.wdata, s_q.wstrb);
            `OFS_EVENT_SEL_1: s_d.evsel  = merge_bytes(s_q.evsel, s_q.wdata, s_q.wstrb);
            `OFS_IRQ_MASK:    s_d.mask   = s_q.wdata[`IRQ_WIDTH-1:0];
            `OFS_IRQ_STATUS:  s_d.status = s_q.status & ~s_q.wdata[`IRQ_WIDTH-1:0];
            default:          s_d.cfg    = s_d.cfg;
         endcase
      end

      // Events win over a clearing write in the same cycle.
      // (RQ14) negative counters raise interrupts
      ev[`IRQ_MCHECK]   = mc_cause;
      ev[`IRQ_CNT3_NEG] = s_q.cnt3[31];
      ev[`IRQ_CNT4_NEG] = s_q.cnt4[31];
      s_d.status = s_d.status | ev;
      s_d.irq    = |(s_d.status & s_d.mask);

      // (RQ1) master enable on all sources
      // (RQ2) machine-check gate picks outcome
      s_d.mc_take = mc_cause && machine_check_gate;
      s_d.chkstop = s_q.chkstop || (mc_cause && !machine_check_gate);

      // (RQ6) snoop high restore control
      s_d.snoop_rest = !s_q.cfg[`CFG_SNOOP_NORESTORE];
      // (RQ9) instruction cache bypass
      // The start pulse blocks the cycle before the cache itself reports busy.
      s_d.ic_act = s_q.cfg[`CFG_ICACHE_EN] && !icache_inval_busy && !s_q.cfg[`CFG_ICACHE_INVAL]
                   && !s_q.ic_inv;
      // (RQ10) data cache bypass
      s_d.dc_act = s_q.cfg[`CFG_DCACHE_EN] && !dcache_inval_busy && !s_q.cfg[`CFG_DCACHE_INVAL]
                   && !s_q.dc_inv;
      // (RQ11) locked caches never allocate
      s_d.ic_na = s_q.cfg[`CFG_ICACHE_LOCK];
      s_d.dc_na = s_q.cfg[`CFG_DCACHE_LOCK];
      // (RQ16) invalidate only an enabled cache
      s_d.ic_inv = s_q.cfg[`CFG_ICACHE_INVAL] && s_q.cfg[`CFG_ICACHE_EN];
      s_d.dc_inv = s_q.cfg[`CFG_DCACHE_INVAL] && s_q.cfg[`CFG_DCACHE_EN];
      // (RQ12) block-zero under lock
      s_d.align_exc = dcbz_exec && s_q.cfg[`CFG_DCACHE_LOCK];

      // Read channel: one outstanding read, answered the cycle after it is taken.
      if (s_q.rvalid && s_axi_rready)
      begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end
      if (s_q.arready && s_axi_arvalid)
      begin
         s_d.arready = 1'b0;
         s_d.rvalid  = 1'b1;
         s_d.rresp   = is_mapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         case (s_axi_araddr)
            `OFS_HW_CONFIG_0:  s_d.rdata = s_q.cfg;
            // (RQ13) pins in low nibble only
            `OFS_PLL_READBACK: s_d.rdata = {28'h0, pll_cfg_pins};
            `OFS_PERF_CNT_3:   s_d.rdata = s_q.cnt3;
            `OFS_PERF_CNT_4:   s_d.rdata = s_q.cnt4;
            `OFS_EVENT_SEL_1:  s_d.rdata = s_q.evsel;
            `OFS_IRQ_STATUS:   s_d.rdata = {29'h0, s_q.status};
            `OFS_IRQ_MASK:     s_d.rdata = {29'h0, s_q.mask};
            default:           s_d.rdata = 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // (RQ8) hard reset clears the not-hard-reset flag
         s_q         <= '0;
         s_q.wst     <= wr_idle;
         s_q.awready <= 1'b1;
         s_q.wready  <= 1'b1;
         s_q.arready <= 1'b1;
         s_q.snoop_rest <= 1'b1;
         s_q.cfg     <= `CFG_RESET;
         s_q.evsel   <= `EVSEL_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready      = s_q.awready;
   assign s_axi_wready       = s_q.wready;
   assign s_axi_bvalid       = s_q.bvalid;
   assign s_axi_bresp        = s_q.bresp;
   assign s_axi_arready      = s_q.arready;
   assign s_axi_rvalid       = s_q.rvalid;
   assign s_axi_rdata        = s_q.rdata;
   assign s_axi_rresp        = s_q.rresp;
   assign machine_check_take = s_q.mc_take;
   assign checkstop          = s_q.chkstop;
   assign snoop_restore_en   = s_q.snoop_rest;
   assign icache_active      = s_q.ic_act;
   assign dcache_active      = s_q.dc_act;
   assign icache_no_alloc    = s_q.ic_na;
   assign dcache_no_alloc    = s_q.dc_na;
   assign icache_inval_start = s_q.ic_inv;
   assign dcache_inval_start = s_q.dc_inv;
   assign dcbz_align_exc     = s_q.align_exc;
   assign irq                = s_q.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   mc_master_gate_a: assert property ( // (RQ1)
      !s_q.cfg[`CFG_MC_PIN_EN] |=> !machine_check_take && !($rose(checkstop)))
      else $error("machine check raised while master enable clear");
   mc_gate_take_a: assert property ( // (RQ2)
      machine_check_input && s_q.cfg[`CFG_MC_PIN_EN] && machine_check_gate
      |=> machine_check_take)
      else $error("gated machine check not taken");
   cache_par_gate_a: assert property ( // (RQ3)
      !machine_check_input && !addr_parity_err && !data_parity_err
      && !s_q.cfg[`CFG_CACHE_PAR_EN] |=> !machine_check_take)
      else $error("cache parity machine check while disabled");
   addr_par_gate_a: assert property ( // (RQ4)
      addr_parity_err && s_q.cfg[`CFG_ADDR_PAR_EN] && s_q.cfg[`CFG_MC_PIN_EN]
      && machine_check_gate |=> machine_check_take)
      else $error("address parity machine check missing");
   data_par_gate_a: assert property ( // (RQ5)
      data_parity_err && s_q.cfg[`CFG_DATA_PAR_EN] && s_q.cfg[`CFG_MC_PIN_EN]
      && machine_check_gate |=> machine_check_take)
      else $error("data parity machine check missing");
   snoop_restore_a: assert property ( // (RQ6)
      s_q.cfg[`CFG_SNOOP_NORESTORE] |=> !snoop_restore_en)
      else $error("snoop restore still enabled");
   dcache_bypass_a: assert property ( // (RQ10)
      !s_q.cfg[`CFG_DCACHE_EN] |=> !dcache_active)
      else $error("data cache active while disabled");
   inval_self_clear_a: assert property ( // (RQ16)
      s_q.cfg[`CFG_ICACHE_INVAL] && s_q.cfg[`CFG_ICACHE_EN]
      |=> !s_q.cfg[`CFG_ICACHE_INVAL] && icache_inval_start)
      else $error("instruction invalidate did not start and clear");
   inval_block_a: assert property ( // (RQ16)
      icache_inval_start |=> !icache_active)
      else $error("instruction cache active during invalidate");
   unused_zero_a: assert property ( // (RQ17)
      (s_q.cfg & ~`CFG_WRITE_MASK) == 32'h0)
      else $error("unused configuration bit set");
   lock_align_a: assert property ( // (RQ12)
      dcbz_exec && s_q.cfg[`CFG_DCACHE_LOCK] |=> dcbz_align_exc)
      else $error("block zero under lock missed alignment");

endmodule : hw_impl_control_regs

// *** bench/snoop_bus_model.sv ***
// Far-side model: cache invalidate engines and the pulled-up snoop response lines.
`timescale 1ns/1ps
module snoop_bus_model #(
   parameter int INVAL_CYCLES = 1
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic assert_snoop,
   input  wire logic icache_inval_start,
   input  wire logic dcache_inval_start,
   output logic      icache_inval_busy,
   output logic      dcache_inval_busy,
   output logic      shared_snoop_response,
   output logic      address_retry_response
);
   typedef struct packed {
      logic [3:0] icnt;
      logic [3:0] dcnt;
      logic       low;
   } model_state_type;
   model_state_type state_q, state_d;

   always_comb
   begin
      state_d = state_q;
      if (icache_inval_start)
         state_d.icnt = 4'(INVAL_CYCLES);
      else if (state_q.icnt != 4'h0)
         state_d.icnt = state_q.icnt - 4'h1;
      if (dcache_inval_start)
         state_d.dcnt = 4'(INVAL_CYCLES);
      else if (state_q.dcnt != 4'h0)
         state_d.dcnt = state_q.dcnt - 4'h1;
      state_d.low = assert_snoop;
   end

   always_ff @(posedge aclk)
      if (!aresetn)
         state_q <= '0;
      else
         state_q <= state_d;

   assign icache_inval_busy = (state_q.icnt != 4'h0);
   assign dcache_inval_busy = (state_q.dcnt != 4'h0);
   // system restores high
   // The pull-up returns both lines high even when the device stops driving them.
   assign shared_snoop_response  = ~state_q.low;
   assign address_retry_response = ~state_q.low;
endmodule : snoop_bus_model

// *** bench/hw_impl_control_regs_tb.sv ***
// Self-checking bench for the implementation control register bank.
`timescale 1ns/1ps
`include "hw_impl_control_regs.svh"
module hw_impl_control_regs_tb;
   import hw_impl_control_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, machine_check_input, cache_parity_err, addr_parity_err;
   logic data_parity_err, machine_check_gate, dcbz_exec, icache_inval_busy;
   logic dcache_inval_busy, machine_check_take, checkstop, snoop_restore_en;
   logic icache_active, dcache_active, icache_no_alloc, dcache_no_alloc, irq;
   logic icache_inval_start, dcache_inval_start, dcbz_align_exc, assert_snoop;
   logic shared_snoop_response, address_retry_response;
   addr_type   s_axi_awaddr, s_axi_araddr;
   word_type   s_axi_wdata, s_axi_rdata, rd;
   resp_type   s_axi_bresp, s_axi_rresp, rs;
   logic [3:0] s_axi_wstrb, pll_cfg_pins, src;
   logic [7:0] perf_events;
   int         n_mismatch = 0, checked = 0, n_istart = 0, n_dstart = 0;

   assign {data_parity_err, addr_parity_err, cache_parity_err, machine_check_input} = src;

   hw_impl_control_regs i_hw_impl_control_regs (
      .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .machine_check_input, .cache_parity_err,
      .addr_parity_err, .data_parity_err, .machine_check_gate, .pll_cfg_pins,
      .perf_events, .dcbz_exec, .icache_inval_busy, .dcache_inval_busy,
      .machine_check_take, .checkstop, .snoop_restore_en, .icache_active,
      .dcache_active, .icache_no_alloc, .dcache_no_alloc, .icache_inval_start,
      .dcache_inval_start, .dcbz_align_exc, .irq);

   // A slow invalidate lets the bench see the cache held off after the write ends.
   snoop_bus_model #(.INVAL_CYCLES(8)) i_snoop_bus_model (
      .aclk, .aresetn, .assert_snoop, .icache_inval_start, .dcache_inval_start,
      .icache_inval_busy, .dcache_inval_busy, .shared_snoop_response,
      .address_retry_response);

   // ---------------------------------------------------------------
   // Clock, monitors and shared tasks
   // ---------------------------------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      if (icache_inval_start === 1'b1) n_istart++;
      if (dcache_inval_start === 1'b1) n_dstart++;
   end

   task automatic chk(input word_type g, input word_type e);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic cb(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask : cb

   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : do_reset

   task automatic settle();
      repeat (2) @(posedge aclk);
      #1;
   endtask : settle

   task automatic wr(input addr_type a, input word_type d, input logic [3:0] s = 4'hf);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rchk(input addr_type a, input word_type e);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(rd, e);
   endtask : rchk

   task automatic pulse(input logic [7:0] e, input int n);
      perf_events <= e;
      repeat (n) @(posedge aclk);
      perf_events <= 8'h00;
   endtask : pulse

   task automatic blkz_chk(input logic e);
      @(posedge aclk);
      dcbz_exec <= 1'b1;
      @(posedge aclk);
      dcbz_exec <= 1'b0;
      #1 cb(dcbz_align_exc, e);
   endtask : blkz_chk

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_cfg_bits();
      rchk(`OFS_HW_CONFIG_0, 32'h0);
      cb(snoop_restore_en, 1'b1);
      wr(`OFS_HW_CONFIG_0, 32'hffc07f70);
      rchk(`OFS_HW_CONFIG_0, 32'h0);
      wr(`OFS_HW_CONFIG_0, 32'h0000808f);
      rchk(`OFS_HW_CONFIG_0, 32'h0000808f);
      do_reset();
      rchk(`OFS_HW_CONFIG_0, 32'h0);
   endtask : t_cfg_bits

   task automatic t_mcheck();
      logic [3:0] pat [4] = '{4'h0, 4'h1, 4'hf, 4'he};
      machine_check_gate <= 1'b1;
      foreach (pat[p])
      begin
         wr(`OFS_HW_CONFIG_0, {28'h0, pat[p]});
         for (int i = 0; i < 4; i++)
         begin
            src <= 4'h1 << i;
            @(posedge aclk);
            src <= 4'h0;
            #1 cb(machine_check_take, pat[p][0] & (i == 0 | pat[p][i]));
            @(posedge aclk);
         end
      end
      rchk(`OFS_IRQ_STATUS, 32'h1);
      cb(irq, 1'b0);
      wr(`OFS_IRQ_MASK, 32'h1);
      settle();
      cb(irq, 1'b1);
      wr(`OFS_IRQ_STATUS, 32'h1);
      settle();
      cb(irq, 1'b0);
      rchk(`OFS_IRQ_STATUS, 32'h0);
      machine_check_gate <= 1'b0;
      wr(`OFS_HW_CONFIG_0, 32'h1);
      src <= 4'h1;
      @(posedge aclk);
      src <= 4'h0;
      #1 cb(machine_check_take, 1'b0);
      settle();
      cb(checkstop, 1'b1);
      do_reset();
      cb(checkstop, 1'b0);
   endtask : t_mcheck

   task automatic t_count();
      wr(`OFS_EVENT_SEL_1, 32'h0502);
      wr(`OFS_PERF_CNT_3, 32'h7ffffffe);
      wr(`OFS_PERF_CNT_4, 32'h12345678);
      wr(`OFS_PERF_CNT_4, 32'h000000aa, 4'h1);
      rchk(`OFS_PERF_CNT_4, 32'h123456aa);
      rchk(`OFS_IRQ_STATUS, 32'h0);
      pulse(8'h04, 3);
      rchk(`OFS_PERF_CNT_3, 32'h80000001);
      rchk(`OFS_PERF_CNT_4, 32'h123456aa);
      pulse(8'h20, 2);
      rchk(`OFS_PERF_CNT_4, 32'h123456ac);
      rchk(`OFS_PERF_CNT_3, 32'h80000001);
      rchk(`OFS_IRQ_STATUS, 32'h2);
      wr(`OFS_IRQ_MASK, 32'h4);
      settle();
      cb(irq, 1'b0);
      wr(`OFS_IRQ_MASK, 32'h2);
      settle();
      cb(irq, 1'b1);
   endtask : t_count

   task automatic t_pll();
      pll_cfg_pins <= 4'ha;
      rchk(`OFS_PLL_READBACK, 32'ha);
      wr(`OFS_PLL_READBACK, 32'hffffffff);
      chk({30'h0, rs}, {30'h0, `AXI_RESP_OKAY});
      pll_cfg_pins <= 4'h5;
      rchk(`OFS_PLL_READBACK, 32'h5);
      wr(8'h1c, 32'h1);
      chk({30'h0, rs}, {30'h0, `AXI_RESP_SLVERR});
      rchk(8'h1c, 32'h0);
      chk({30'h0, rs}, {30'h0, `AXI_RESP_SLVERR});
   endtask : t_pll

   task automatic t_cache();
      wr(`OFS_HW_CONFIG_0, 32'h000b0000);
      settle();
      cb(icache_active, 1'b1);
      cb(dcache_active, 1'b1);
      cb(dcache_no_alloc, 1'b1);
      cb(icache_no_alloc, 1'b0);
      blkz_chk(1'b1);
      wr(`OFS_HW_CONFIG_0, 32'h00040000);
      settle();
      cb(icache_active, 1'b0);
      cb(dcache_active, 1'b0);
      cb(icache_no_alloc, 1'b1);
      blkz_chk(1'b0);
      wr(`OFS_HW_CONFIG_0, 32'h00130000);
      settle();
      cb(icache_active, 1'b0);
      chk(word_type'(n_istart), 32'h1);
      repeat (12) @(posedge aclk);
      cb(icache_active, 1'b1);
      wr(`OFS_HW_CONFIG_0, 32'h00210000);
      rchk(`OFS_HW_CONFIG_0, 32'h00010000);
      chk(word_type'(n_dstart), 32'h0);
      wr(`OFS_HW_CONFIG_0, 32'h00230000);
      settle();
      chk(word_type'(n_dstart), 32'h1);
      cb(dcache_active, 1'b0);
   endtask : t_cache

   task automatic t_snoop();
      wr(`OFS_HW_CONFIG_0, 32'h80);
      settle();
      cb(snoop_restore_en, 1'b0);
      @(posedge aclk);
      assert_snoop <= 1'b1;
      @(posedge aclk);
      assert_snoop <= 1'b0;
      #1 cb(shared_snoop_response, 1'b0);
      @(posedge aclk);
      #1 cb(address_retry_response, 1'b1);
      wr(`OFS_HW_CONFIG_0, 32'h0);
      settle();
      cb(snoop_restore_en, 1'b1);
   endtask : t_snoop

   initial
   begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {dcbz_exec, assert_snoop, machine_check_gate} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {src, pll_cfg_pins, perf_events} = '0;
      do_reset();
      t_cfg_bits();
      t_mcheck();
      t_count();
      t_pll();
      t_cache();
      t_snoop();
      stop_test();
   end

   // The whole sequence needs a few hundred cycles; this bound cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      stop_test();
   end
endmodule : hw_impl_control_regs_tb
